/* rtl/flash_adc_output_phase_control.sv */
// phase selection, conversion pipeline and three-state output control
`timescale 1ns/100ps
`default_nettype none
// Operation
// - the code is eight active-high bits, bit 1 lsb, plus overflow.
// - all outputs enable low floats the data bits and overflow.
// - enabled, data drives unless data disable is high; overflow drives.
// - with phase low, sampling happens while the converter clock is low.
// - with phase low, auto-balance happens while the clock is high.
// - phase high swaps the two periods, complementing the clock.
// - a result shows at the next sample end; samples stay under 500 ns.
module flash_adc_output_phase_control #(
  parameter int CODE_W     = adc_ctl_pkg::CODE_W,
  parameter int FIFO_DEPTH = adc_ctl_pkg::FIFO_DEPTH
) (
  input  wire logic              clk,
  input  wire logic              reset_n,
  input  wire logic              conv_clk,
  input  wire logic              phase_ctl,
  input  wire logic [CODE_W:0]   comparator_code,
  input  wire logic              data_disable_high,
  input  wire logic              all_outputs_enable_n,
  output logic [CODE_W-1:0]      code_out,
  output logic [CODE_W-1:0]      code_oe,
  output logic                   overflow_flag,
  output logic                   overflow_oe,
  output logic                   sampling,
  output logic                   balancing,
  output logic                   sample_too_long
);
  // control pin inputs pass two flops before use; the comparator code is taken direct
  logic [1:0]          clk_s_q;
  logic [1:0]          ph_s_q;
  logic [1:0]          den_s_q;
  logic [1:0]          aen_s_q;
  logic                eff_prev_q;
  logic [CODE_W:0]     stage1_q;
  logic                captured_q;
  logic [CODE_W-1:0]   code_q;
  logic                ovf_q;
  logic [15:0]         samp_cnt_q;
  logic                too_long_q;
  adc_ctl_pkg::phase_t state_q;
  adc_ctl_pkg::phase_t state_d;

  // edge test shared by both directions of the effective clock
  function automatic logic edge_to(input logic was,
                                   input logic cur,
                                   input logic lvl);
    edge_to = (was != cur) && (cur == lvl);
  endfunction : edge_to

  // state test shared by the two phase outputs
  function automatic logic in_state(input adc_ctl_pkg::phase_t s,
                                    input adc_ctl_pkg::phase_t want);
    in_state = (s == want);
  endfunction : in_state

  // clock and phase pins share one delay, so their xor stays aligned
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      clk_s_q <= 2'h0;
    end else begin
      clk_s_q <= {clk_s_q[0], conv_clk};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ph_s_q <= 2'h0;
    end else begin
      ph_s_q <= {ph_s_q[0], phase_ctl};
    end
  end

  // data lines start floated until the enable pins have been seen
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      den_s_q <= 2'h3;
    end else begin
      den_s_q <= {den_s_q[0], data_disable_high};
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      aen_s_q <= 2'h0;
    end else begin
      aen_s_q <= {aen_s_q[0], all_outputs_enable_n};
    end
  end

  // phase high complements the clock as it enters
  wire eff_clk   = clk_s_q[1] ^ ph_s_q[1];
  wire is_sample = !eff_clk;
  wire is_bal    = eff_clk;
  // edges of the synced level, one cycle pulses
  wire fall_edge = edge_to(eff_prev_q, eff_clk, 1'b0);
  wire rise_edge = edge_to(eff_prev_q, eff_clk, 1'b1);
  // sample ends on the rising edge of the effective clock
  wire samp_end  = rise_edge;

  // last effective level, for edge detection
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eff_prev_q <= 1'b0;
    end else begin
      eff_prev_q <= eff_clk;
    end
  end

  // idle lasts one cycle, then follows whichever phase the pins show
  always_comb begin
    state_d = state_q;
    case (state_q)
      adc_ctl_pkg::PH_IDLE: begin
        state_d = is_sample ? adc_ctl_pkg::PH_SAMPLE : adc_ctl_pkg::PH_BALANCE;
      end
      adc_ctl_pkg::PH_SAMPLE: begin
        if (is_bal) state_d = adc_ctl_pkg::PH_BALANCE;
      end
      adc_ctl_pkg::PH_BALANCE: begin
        if (is_sample) state_d = adc_ctl_pkg::PH_SAMPLE;
      end
      default: state_d = adc_ctl_pkg::PH_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      state_q <= adc_ctl_pkg::PH_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // latch at sample end, hand on at balance end, register at next sample end
  word_stream_if #(.W(CODE_W + 1)) to_fifo ();
  logic             rd_valid;
  logic [CODE_W:0]  rd_data;
  wire              load = samp_end && rd_valid;
  // pushing at balance end leaves the word ready for the next sample end
  assign to_fifo.valid = captured_q && fall_edge;
  assign to_fifo.data  = stage1_q;

  // comparator status held at the end of each sample
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stage1_q   <= '0;
      captured_q <= 1'b0;
    end else if (samp_end) begin
      stage1_q   <= comparator_code;
      captured_q <= 1'b1;
    end
  end

  // pushes and pops alternate, so the fifo never holds more than a word
  code_fifo #(.W(CODE_W + 1), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clk      (clk),
    .reset_n  (reset_n),
    .wr       (to_fifo),
    .rd_ready (samp_end),
    .rd_valid (rd_valid),
    .rd_data  (rd_data)
  );

  // output register changes only on a load, steady otherwise
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      code_q <= adc_ctl_pkg::CODE_RESET;
    end else if (load) begin
      code_q <= rd_data[CODE_W-1:0];
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      ovf_q <= adc_ctl_pkg::OVF_RESET;
    end else if (load) begin
      ovf_q <= rd_data[CODE_W];
    end
  end

  // droop guard: flag a sample phase longer than the limit
  wire at_limit = samp_cnt_q >= 16'(adc_ctl_pkg::SAMPLE_MAX_CYC);

  // counter saturates at the limit so a long standby never wraps it
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      samp_cnt_q <= '0;
    end else if (!is_sample) begin
      samp_cnt_q <= '0;
    end else if (!at_limit) begin
      samp_cnt_q <= samp_cnt_q + 16'h0001;
    end
  end

  // only reset and leaving the sample phase clear the flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      too_long_q <= 1'b0;
    end else if (!is_sample) begin
      too_long_q <= 1'b0;
    end else if (at_limit) begin
      too_long_q <= 1'b1;
    end
  end

  // the _n enable floats all nine lines when low, not when high
  wire drive_all  = aen_s_q[1];
  wire drive_data = drive_all && !den_s_q[1];

  // phase outputs decode the registered state, so they never glitch
  assign code_out        = code_q;
  assign overflow_flag   = ovf_q;
  assign code_oe         = {CODE_W{drive_data}};
  assign overflow_oe     = drive_all;
  assign sampling        = in_state(state_q, adc_ctl_pkg::PH_SAMPLE);
  assign balancing       = in_state(state_q, adc_ctl_pkg::PH_BALANCE);
  assign sample_too_long = too_long_q;
endmodule : flash_adc_output_phase_control
`default_nettype wire

/* common/adc_ctl_pkg.sv */
// shared constants for the flash converter output and phase control
`default_nettype none
package adc_ctl_pkg;
  localparam int CODE_W           = 8;
  localparam int FIFO_DEPTH       = 8;
  localparam int CLK_PERIOD_PS    = 8000;
  localparam int SAMPLE_MAX_NS    = 500;
  // longest time rounds down, never below one cycle
  localparam int SAMPLE_MAX_CYC   =
    (SAMPLE_MAX_NS * 1000) / CLK_PERIOD_PS < 1 ? 1 :
    (SAMPLE_MAX_NS * 1000) / CLK_PERIOD_PS;
  localparam int EDGES_TO_RESULT  = 2;
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic       OVF_RESET  = 1'b0;
  typedef enum logic [1:0] {
    PH_IDLE,
    PH_SAMPLE,
    PH_BALANCE
  } phase_t;
endpackage : adc_ctl_pkg
`default_nettype wire

/* common/word_stream_if.sv */
// valid/ready stream of conversion words between the core and its fifo
`timescale 1ns/100ps
`default_nettype none
interface word_stream_if #(parameter int W = 9);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;
  modport source (output valid, output data, input ready);
  modport sink   (input valid, input data, output ready);
endinterface : word_stream_if
`default_nettype wire

/* rtl/code_fifo.sv */
// parameterised word fifo with valid and ready on both sides
`timescale 1ns/100ps
`default_nettype none
module code_fifo #(
  parameter int W     = 9,
  parameter int DEPTH = 8
) (
  input  wire logic   clk,
  input  wire logic   reset_n,
  word_stream_if.sink wr,
  input  wire logic   rd_ready,
  output logic        rd_valid,
  output logic [W-1:0] rd_data
);
  localparam int AW = $clog2(DEPTH);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wp_q;
  logic [AW-1:0] rp_q;
  logic [AW:0]   cnt_q;
  wire           full  = (cnt_q == (AW+1)'(DEPTH));
  wire           empty = (cnt_q == '0);
  wire           push  = wr.valid && !full;
  wire           pop   = rd_ready && !empty;

  assign wr.ready = !full;
  assign rd_valid = !empty;
  assign rd_data  = mem[rp_q];

  function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
    bump = (p == AW'(DEPTH - 1)) ? '0 : p + 1'b1;
  endfunction : bump

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wp_q] <= wr.data;
    end
  end

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wp_q  <= '0;
      rp_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push) wp_q <= bump(wp_q);
      if (pop) rp_q <= bump(rp_q);
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule : code_fifo
`default_nettype wire

/* tb/adc_ctl_props.sv */
// checker on the converter control top ports
`timescale 1ns/100ps
`default_nettype none
module adc_ctl_props (
  input wire logic       clk,
  input wire logic       reset_n,
  input wire logic       conv_clk,
  input wire logic       phase_ctl,
  input wire logic       data_disable_high,
  input wire logic       all_outputs_enable_n,
  input wire logic [7:0] code_out,
  input wire logic [7:0] code_oe,
  input wire logic       overflow_oe,
  input wire logic       sampling,
  input wire logic       balancing,
  input wire logic       sample_too_long
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  logic [6:0] run_q;
  // saturates so a long standby never wraps
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) run_q <= 7'h00;
    else if (!sampling) run_q <= 7'h00;
    else if (run_q != 7'h7F) run_q <= run_q + 7'h01;
  end
  a_all_off: assert property (!all_outputs_enable_n [*4] |->
    code_oe == 8'h00 && !overflow_oe) else $error("outputs not floated");
  a_data_on: assert property (
    (all_outputs_enable_n && !data_disable_high) [*4] |->
    code_oe == 8'hFF && overflow_oe) else $error("data not on");
  a_data_float: assert property (
    (all_outputs_enable_n && data_disable_high) [*4] |->
    code_oe == 8'h00 && overflow_oe) else $error("data not off");
  a_oe_whole: assert property (code_oe == 8'h00 || code_oe == 8'hFF)
    else $error("split data enable");
  a_phase_excl: assert property (!(sampling && balancing))
    else $error("both phases");
  a_sample_low: assert property (
    (conv_clk == phase_ctl) [*4] |-> sampling) else $error("no sampling");
  a_balance_high: assert property (
    (conv_clk != phase_ctl) [*4] |-> balancing)
    else $error("no balancing");
  a_code_hold: assert property (sampling [*4] |-> $stable(code_out))
    else $error("code moved");
  a_sample_limit: assert property (
    sampling && run_q >= 7'h3E |-> sample_too_long)
    else $error("long sample unflagged");
endmodule : adc_ctl_props
bind flash_adc_output_phase_control adc_ctl_props i_props (.clk(clk),
  .reset_n(reset_n), .conv_clk(conv_clk), .phase_ctl(phase_ctl),
  .data_disable_high(data_disable_high),
  .all_outputs_enable_n(all_outputs_enable_n), .code_out(code_out),
  .code_oe(code_oe), .overflow_oe(overflow_oe), .sampling(sampling),
  .balancing(balancing), .sample_too_long(sample_too_long));
`default_nettype wire

/* tb/code_capture.sv */
// downstream capture of the nine output pins
`timescale 1ns/100ps
`default_nettype none
module code_capture (
  input  wire logic       clk,
  input  wire logic [8:0] drv,
  input  wire logic [8:0] oe,
  output logic [8:0]      pins_q
);
  // a floating line shows the inverse, never stale data
  always_ff @(posedge clk) pins_q <= (oe & drv) | (~oe & ~pins_q);
endmodule : code_capture
`default_nettype wire

/* tb/test_flash_adc_output_phase_control.sv */
// random conversions, phase swap, enables and sample limit
`timescale 1ns/100ps
`default_nettype none
module test_flash_adc_output_phase_control;
  logic clk = 1'b0, reset_n = 1'b0, cclk = 1'b0, ph = 1'b0;
  logic ddh = 1'b0, en_n = 1'b1, ovf, ovf_oe, smp, bal, tl, fl;
  logic [8:0] cin = 9'h000, prev = 9'h000, shown, pins, want;
  logic [7:0] cout, coe;
  logic [31:0] rng = 32'd54;
  int n_errors = 0, samples_checked = 0;
  initial forever #4 clk = ~clk;
  flash_adc_output_phase_control i_dut (.clk(clk), .reset_n(reset_n),
    .conv_clk(cclk), .phase_ctl(ph), .comparator_code(cin),
    .data_disable_high(ddh), .all_outputs_enable_n(en_n), .code_out(cout),
    .code_oe(coe), .overflow_flag(ovf), .overflow_oe(ovf_oe),
    .sampling(smp), .balancing(bal), .sample_too_long(tl));
  code_capture i_cap (.clk(clk), .drv({ovf, cout}), .oe({ovf_oe, coe}),
    .pins_q(pins));
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] r;
    r = s ^ (s << 13);
    r = r ^ (r >> 17);
    xs = r ^ (r << 5);
  endfunction : xs
  task automatic chk_word(input string w, input logic [8:0] e,
                          input logic [8:0] g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", w, e, g);
    end
  endtask : chk_word
  task automatic chk_flag(input string w, input logic e, input logic g);
    samples_checked++;
    if (g !== e) begin
      n_errors++;
      $display("unexpected %s: expected %b seen %b", w, e, g);
    end
  endtask : chk_flag
  task automatic end_sim;
    $display("errors %0d checked %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : end_sim
  task automatic eff(input logic lvl, input int n);
    @(negedge clk) cclk = lvl ^ ph;
    repeat (n - 1) @(negedge clk);
  endtask : eff
  // sample low, end on the rising edge; next end shows the result
  task automatic conv(input logic [8:0] v, input logic ck);
    cin = v;
    eff(1'b0, 8);
    chk_flag("sampling", 1'b1, smp);
    eff(1'b1, 10);
    chk_flag("balancing", 1'b1, bal);
    if (ck) chk_word("code", prev, {ovf, cout});
    shown = prev;
    prev = v;
  endtask : conv
  initial begin
    repeat (4) @(negedge clk);
    reset_n = 1'b1;
    for (int p = 0; p < 2; p++) begin
      ph = p[0];
      for (int i = 0; i < 12; i++) begin
        rng = xs(rng);
        conv(i == 3 ? 9'h1FF : (i == 4 ? 9'h000 : rng[8:0]), i > 1);
      end
    end
    for (int k = 0; k < 3; k++) begin
      en_n = (k != 2);
      ddh = (k == 1);
      repeat (6) @(negedge clk);
      want = (k == 0) ? 9'h0FF : 9'h000;
      chk_word("code_oe", want, {1'b0, coe});
      chk_flag("overflow_oe", k != 2, ovf_oe);
      if (k == 0) chk_word("pins", shown, pins);
      if (k == 1) chk_flag("ovf pin", shown[8], pins[8]);
      fl = pins[8];
      @(negedge clk);
      if (k == 2) chk_flag("ovf float", ~fl, pins[8]);
    end
    // standby left in sample past the droop limit
    eff(1'b0, 75);
    chk_flag("too_long", 1'b1, tl);
    end_sim();
  end
  initial begin
    #(8 * 5000);
    n_errors++;
    end_sim();
  end
endmodule : test_flash_adc_output_phase_control
`default_nettype wire
